// [hdl/pse_defines.svh]
`ifndef PSE_DEFINES_SVH
`define PSE_DEFINES_SVH

// ==========================================
// Parameter indices and subindices
`define PSE_IDX_SETPOINT    8'h3C
`define PSE_IDX_CONFIG      8'h3D
`define PSE_IDX_CONFIG_EXT  8'h40
`define PSE_SUB_FIRST       8'h01
`define PSE_SUB_SECOND      8'h02
`define PSE_SUB_THIRD       8'h03

// ==========================================
// Mode codes
`define PSE_MODE_OFF        8'h00
`define PSE_MODE_SINGLE     8'h01
`define PSE_MODE_WINDOW     8'h02
`define PSE_MODE_TWO_POINT  8'h03
`define PSE_MODE_CENTERED   8'h04

// ==========================================
// Polarity, substitute and pulse stretch codes
`define PSE_POL_HIGH        8'h00
`define PSE_POL_LOW         8'h01
`define PSE_SUBST_HOLD      8'h00
`define PSE_SUBST_INACTIVE  8'h01
`define PSE_SUBST_ACTIVE    8'h02
`define PSE_STRETCH_OFF     8'h00
`define PSE_STRETCH_AUTO    8'h01
`define PSE_STRETCH_10MS    8'h02
`define PSE_STRETCH_100MS   8'h03
`define PSE_STRETCH_1000MS  8'h04

// ==========================================
// Reserved position codes and range
`define PSE_POS_UNDER       16'h8008
`define PSE_POS_OVER        16'h7FF8
`define PSE_POS_NODATA      16'h7FFC
`define PSE_RANGE_END_RESET 16'h7FF0

// ==========================================
// Process data field positions
`define PSE_PD_POS_LSB      16
`define PSE_PD_SCALE_LSB    8
`define PSE_PD_QUAL_LSB     2
`define PSE_PD_CH2_BIT      1
`define PSE_PD_CH1_BIT      0

// ==========================================
// Timing: milliseconds, clock rate, millisecond tick
`define PSE_CLK_HZ          10000000
`define PSE_MS_CYCLES       (`PSE_CLK_HZ / 1000)
`define PSE_T10_MS          10
`define PSE_T100_MS         100
`define PSE_T1000_MS        1000

`endif

// [hdl/pse_pkg.sv]
package pse_pkg;

	// ==========================================
	// One channel parameter set
	typedef struct packed {
		logic [15:0] first_setpoint;
		logic [15:0] second_setpoint;
		logic [7:0]  polarity;
		logic [7:0]  mode;
		logic [15:0] hysteresis;
		logic [15:0] window_offset;
		logic [7:0]  pulse_stretch;
		logic [7:0]  fault_substitute;
	} pse_chan_cfg_t;

	// Measurement sample from the front end
	typedef struct packed {
		logic [15:0] position;
		logic [7:0]  scale;
		logic [1:0]  quality;
	} pse_meas_t;

	// Parameter access from the link layer
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        channel;
		logic [7:0]  index;
		logic [7:0]  subindex;
		logic [15:0] data;
	} pse_param_req_t;

	typedef enum logic [1:0] {
		PSE_ST_IDLE,
		PSE_ST_STRETCH,
		PSE_ST_WAIT_SEND
	} pse_stretch_state_t;

endpackage

// [hdl/pse_param_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pse_defines.svh"

module pse_param_store (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	// Parameter access
	input  wire pse_pkg::pse_param_req_t req,
	output logic [15:0]                 rd_data,
	output logic                        rd_valid,
	output logic                        rd_error,
	// Parameter sets
	output pse_pkg::pse_chan_cfg_t      cfg [2]
);

	pse_pkg::pse_chan_cfg_t cfg_q [2];

	assign cfg = cfg_q;

	// ==========================================
	// Per-channel parameter storage, all reset to a deactivated channel
	for (genvar c = 0; c < 2; c++) begin : g_chan
		always_ff @(posedge sys_clk) begin
			if (reset) begin
				cfg_q[c] <= '0;
			end else if (req.wr && (req.channel == 1'(c))) begin
				unique case ({req.index, req.subindex})
					{`PSE_IDX_SETPOINT, `PSE_SUB_FIRST}:    cfg_q[c].first_setpoint   <= req.data;
					{`PSE_IDX_SETPOINT, `PSE_SUB_SECOND}:   cfg_q[c].second_setpoint  <= req.data;
					{`PSE_IDX_CONFIG, `PSE_SUB_FIRST}:      cfg_q[c].polarity         <= req.data[7:0];
					{`PSE_IDX_CONFIG, `PSE_SUB_SECOND}:     cfg_q[c].mode             <= req.data[7:0];
					{`PSE_IDX_CONFIG, `PSE_SUB_THIRD}:      cfg_q[c].hysteresis       <= req.data;
					{`PSE_IDX_CONFIG_EXT, `PSE_SUB_FIRST}:  cfg_q[c].window_offset    <= req.data;
					{`PSE_IDX_CONFIG_EXT, `PSE_SUB_SECOND}: cfg_q[c].pulse_stretch    <= req.data[7:0];
					{`PSE_IDX_CONFIG_EXT, `PSE_SUB_THIRD}:  cfg_q[c].fault_substitute <= req.data[7:0];
					default: ;
				endcase
			end
		end
	end

	// Read path; data registered, unknown index flagged
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
			rd_error <= 1'b0;
		end else begin
			rd_valid <= req.rd;
			rd_error <= 1'b0;
			if (req.rd) begin
				unique case ({req.index, req.subindex})
					{`PSE_IDX_SETPOINT, `PSE_SUB_FIRST}:    rd_data <= cfg_q[req.channel].first_setpoint;
					{`PSE_IDX_SETPOINT, `PSE_SUB_SECOND}:   rd_data <= cfg_q[req.channel].second_setpoint;
					{`PSE_IDX_CONFIG, `PSE_SUB_FIRST}:      rd_data <= {8'h00, cfg_q[req.channel].polarity};
					{`PSE_IDX_CONFIG, `PSE_SUB_SECOND}:     rd_data <= {8'h00, cfg_q[req.channel].mode};
					{`PSE_IDX_CONFIG, `PSE_SUB_THIRD}:      rd_data <= cfg_q[req.channel].hysteresis;
					{`PSE_IDX_CONFIG_EXT, `PSE_SUB_FIRST}:  rd_data <= cfg_q[req.channel].window_offset;
					{`PSE_IDX_CONFIG_EXT, `PSE_SUB_SECOND}: rd_data <= {8'h00, cfg_q[req.channel].pulse_stretch};
					{`PSE_IDX_CONFIG_EXT, `PSE_SUB_THIRD}:  rd_data <= {8'h00, cfg_q[req.channel].fault_substitute};
					default: begin
						rd_data  <= 16'h0000;
						rd_error <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// [hdl/pse_stretch.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pse_defines.svh"

module pse_stretch (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// Timing
	input  wire logic       ms_tick,
	input  wire logic       pd_sent,
	// Setting and signal
	input  wire logic [7:0] stretch_sel,
	input  wire logic       active_in,
	output logic            active_out
);

	logic [9:0]                      ms_left_q;
	logic                            seen_q;
	pse_pkg::pse_stretch_state_t     state_q;
	logic [9:0]                      ms_load;

	// Extension length in milliseconds for the timed settings
	always_comb begin
		unique case (stretch_sel)
			`PSE_STRETCH_10MS:   ms_load = 10'(`PSE_T10_MS);
			`PSE_STRETCH_100MS:  ms_load = 10'(`PSE_T100_MS);
			`PSE_STRETCH_1000MS: ms_load = 10'(`PSE_T1000_MS);
			default:             ms_load = 10'h000;
		endcase
	end

	// Minimum pulse: timer or process data send; longer pulses pass untouched
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q   <= pse_pkg::PSE_ST_IDLE;
			ms_left_q <= 10'h000;
			seen_q    <= 1'b0;
		end else begin
			unique case (state_q)
				pse_pkg::PSE_ST_IDLE: begin
					seen_q <= 1'b0;
					if (active_in && stretch_sel == `PSE_STRETCH_AUTO) begin
						state_q <= pse_pkg::PSE_ST_WAIT_SEND;
					end else if (active_in && ms_load != 10'h000) begin
						ms_left_q <= ms_load;
						state_q   <= pse_pkg::PSE_ST_STRETCH;
					end
				end
				pse_pkg::PSE_ST_STRETCH: begin
					if (ms_tick && ms_left_q != 10'h000) begin
						ms_left_q <= ms_left_q - 10'h001;
					end
					if (ms_left_q == 10'h000 && !active_in) begin
						state_q <= pse_pkg::PSE_ST_IDLE;
					end
				end
				pse_pkg::PSE_ST_WAIT_SEND: begin
					// Event held until a transmission carried it
					if (pd_sent) begin
						seen_q <= 1'b1;
					end
					if ((seen_q || pd_sent) && !active_in) begin
						state_q <= pse_pkg::PSE_ST_IDLE;
					end
				end
				default: state_q <= pse_pkg::PSE_ST_IDLE;
			endcase
		end
	end

	assign active_out = active_in || (state_q != pse_pkg::PSE_ST_IDLE);

endmodule

`default_nettype wire

// [hdl/pse_eval.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pse_defines.svh"

module pse_eval (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    reset,
	// Measurement front end
	input  wire pse_pkg::pse_meas_t      meas,
	input  wire logic                    meas_valid,
	input  wire logic                    meas_under,
	input  wire logic                    meas_over,
	input  wire logic [15:0]             range_end,
	// Parameter access from the link layer
	input  wire pse_pkg::pse_param_req_t param_req,
	output logic [15:0]                  param_rd_data,
	output logic                         param_rd_valid,
	output logic                         param_rd_error,
	// Cyclic process data
	input  wire logic                    pd_sent,
	output logic [31:0]                  process_data
);

	pse_pkg::pse_chan_cfg_t cfg [2];
	logic [15:0]            pos_q;
	logic [7:0]             scale_q;
	logic [1:0]             qual_q;
	logic                   fault_q;
	logic [13:0]            ms_div_q;
	logic                   ms_tick;
	logic [1:0]             chan_bit;

	// ==========================================
	// Parameter storage
	pse_param_store pse_param_store_i (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.req      (param_req),
		.rd_data  (param_rd_data),
		.rd_valid (param_rd_valid),
		.rd_error (param_rd_error),
		.cfg      (cfg)
	);

	// ==========================================
	// Measurement capture with reserved codes
	// Front end is on this clock, so no synchroniser is needed
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pos_q   <= `PSE_POS_NODATA;
			scale_q <= 8'h00;
			qual_q  <= 2'h0;
			fault_q <= 1'b1;
		end else begin
			scale_q <= meas.scale;
			qual_q  <= meas.quality;
			fault_q <= !meas_valid || meas_under || meas_over;
			if (!meas_valid) begin
				pos_q <= `PSE_POS_NODATA;
			end else if (meas_under) begin
				pos_q <= `PSE_POS_UNDER;
			end else if (meas_over) begin
				pos_q <= `PSE_POS_OVER;
			end else begin
				pos_q <= meas.position;
			end
		end
	end

	// ==========================================
	// Millisecond enable for pulse stretch timing
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ms_div_q <= 14'h0000;
		end else if (ms_div_q == 14'(`PSE_MS_CYCLES - 1)) begin
			ms_div_q <= 14'h0000;
		end else begin
			ms_div_q <= ms_div_q + 14'h0001;
		end
	end

	assign ms_tick = (ms_div_q == 14'(`PSE_MS_CYCLES - 1));

	// ==========================================
	// Two identical switching channels
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic signed [17:0] pos_s;
		logic signed [17:0] sp1;
		logic signed [17:0] sp2;
		logic signed [17:0] hyst;
		logic signed [17:0] lo;
		logic signed [17:0] hi;
		logic signed [17:0] lo_off;
		logic signed [17:0] hi_off;
		logic signed [17:0] rend;
		logic               act_q;
		logic               act_d;
		logic               stretched;

		assign pos_s = 18'(signed'(pos_q));
		assign sp1   = 18'(signed'(cfg[c].first_setpoint));
		assign sp2   = 18'(signed'(cfg[c].second_setpoint));
		assign rend  = 18'(range_end);

		// Clamp a switch point into zero .. range end
		function automatic logic signed [17:0] clamp(input logic signed [17:0] v, input logic signed [17:0] top);
			if (v < 18'sh00000) begin
				return 18'sh00000;
			end
			if (v > top) begin
				return top;
			end
			return v;
		endfunction

		// Limits per mode; window sorts its setpoints
		always_comb begin
			hyst   = 18'(signed'(cfg[c].hysteresis));
			lo     = 18'sh00000;
			hi     = 18'sh00000;
			unique case (cfg[c].mode)
				`PSE_MODE_WINDOW: begin
					lo = (sp1 < sp2) ? sp1 : sp2;
					hi = (sp1 < sp2) ? sp2 : sp1;
				end
				`PSE_MODE_CENTERED: begin
					lo = sp1 - 18'(signed'(cfg[c].window_offset));
					hi = sp1 + 18'(signed'(cfg[c].window_offset));
				end
				`PSE_MODE_TWO_POINT: begin
					lo   = (sp1 < sp2) ? sp1 : sp2;
					hi   = (sp1 < sp2) ? sp2 : sp1;
					hyst = 18'sh00000;
				end
				`PSE_MODE_SINGLE: begin
					lo = sp1;
					hi = sp1;
				end
				default: hyst = 18'sh00000;
			endcase
			lo_off = clamp(lo - hyst, rend);
			hi_off = clamp(hi + hyst, rend);
		end

		// Activity decision with hysteresis and substitute handling
		always_comb begin
			act_d = act_q;
			// A deactivated channel stays inactive even on a fault
			if (fault_q && (cfg[c].mode inside {`PSE_MODE_SINGLE, `PSE_MODE_WINDOW, `PSE_MODE_TWO_POINT, `PSE_MODE_CENTERED})) begin
				unique case (cfg[c].fault_substitute)
					`PSE_SUBST_INACTIVE: act_d = 1'b0;
					`PSE_SUBST_ACTIVE:   act_d = 1'b1;
					default:             act_d = act_q;
				endcase
			end else begin
				unique case (cfg[c].mode)
					`PSE_MODE_SINGLE: begin
						// Active at or above setpoint, release below it minus hysteresis
						if (pos_s >= clamp(lo, rend)) begin
							act_d = 1'b1;
						end else if (pos_s < lo_off) begin
							act_d = 1'b0;
						end
					end
					`PSE_MODE_WINDOW, `PSE_MODE_CENTERED: begin
						// Equal setpoints in window mode leave the bit unchanged
						if (!(cfg[c].mode == `PSE_MODE_WINDOW && sp1 == sp2)) begin
							if (pos_s >= clamp(lo, rend) && pos_s <= clamp(hi, rend)) begin
								act_d = 1'b1;
							end else if (pos_s < lo_off || pos_s > hi_off) begin
								act_d = 1'b0;
							end
						end
					end
					`PSE_MODE_TWO_POINT: begin
						if (pos_s >= hi) begin
							act_d = 1'b1;
						end else if (pos_s <= lo) begin
							act_d = 1'b0;
						end
					end
					default: act_d = 1'b0;
				endcase
			end
		end

		// Unstretched activity state
		always_ff @(posedge sys_clk) begin
			if (reset) begin
				act_q <= 1'b0;
			end else begin
				act_q <= act_d;
			end
		end

		pse_stretch pse_stretch_i (
			.sys_clk     (sys_clk),
			.reset       (reset),
			.ms_tick     (ms_tick),
			.pd_sent     (pd_sent),
			.stretch_sel (cfg[c].pulse_stretch),
			.active_in   (act_q),
			.active_out  (stretched)
		);

		// Polarity maps the active state onto the bit level
		assign chan_bit[c] = (cfg[c].polarity == `PSE_POL_LOW) ? !stretched : stretched;
	end

	// ==========================================
	// Process data image, registered
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			process_data <= 32'h00000000;
		end else begin
			process_data <= {pos_q, scale_q, 4'h0, qual_q, chan_bit[1], chan_bit[0]};
		end
	end

endmodule

`default_nettype wire

// [verification/pse_eval_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

module pse_eval_asserts (
	// Clock and reset
	input wire logic                    sys_clk,
	input wire logic                    reset,
	// Front end
	input wire pse_pkg::pse_meas_t      meas,
	input wire logic                    meas_valid,
	input wire logic                    meas_under,
	input wire logic                    meas_over,
	input wire logic [15:0]             range_end,
	// Parameter access
	input wire pse_pkg::pse_param_req_t param_req,
	input wire logic [15:0]             param_rd_data,
	input wire logic                    param_rd_valid,
	input wire logic                    param_rd_error,
	// Process data
	input wire logic                    pd_sent,
	input wire logic [31:0]             process_data
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// ==========================================
	// Shadows of channel one settings
	logic [15:0] sp_q;
	logic [7:0]  mode_q;
	logic [7:0]  pol_q;
	logic [2:0]  quiet_q;

	// Quiet counts edges since any write, so the pipeline has settled before judging
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sp_q    <= 16'h0000;
			mode_q  <= 8'h00;
			pol_q   <= 8'h00;
			quiet_q <= 3'h0;
		end else begin
			quiet_q <= param_req.wr ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
			if (param_req.wr && !param_req.channel && param_req.index == 8'h3C && param_req.subindex == 8'h01)
				sp_q <= param_req.data;
			if (param_req.wr && !param_req.channel && param_req.index == 8'h3D && param_req.subindex == 8'h01)
				pol_q <= param_req.data[7:0];
			if (param_req.wr && !param_req.channel && param_req.index == 8'h3D && param_req.subindex == 8'h02)
				mode_q <= param_req.data[7:0];
		end
	end

	// ==========================================
	// Process data image
	property p_nodata;
		!meas_valid && !meas_under && !meas_over |-> ##2 process_data[31:16] == 16'h7FFC;
	endproperty
	a_nodata: assert property (p_nodata) else $error("no-data code missing");

	property p_under;
		meas_valid && meas_under && !meas_over |-> ##2 process_data[31:16] == 16'h8008;
	endproperty
	a_under: assert property (p_under) else $error("below-range code missing");

	property p_over;
		meas_valid && meas_over && !meas_under |-> ##2 process_data[31:16] == 16'h7FF8;
	endproperty
	a_over: assert property (p_over) else $error("above-range code missing");

	property p_pos;
		meas_valid && !meas_under && !meas_over |-> ##2 process_data[31:16] == $past(meas.position, 2);
	endproperty
	a_pos: assert property (p_pos) else $error("position not carried");

	property p_scale;
		1'b1 |-> ##2 process_data[15:8] == $past(meas.scale, 2) && process_data[3:2] == $past(meas.quality, 2);
	endproperty
	a_scale: assert property (p_scale) else $error("scale or quality not carried");

	property p_spare;
		process_data[7:4] == 4'h0;
	endproperty
	a_spare: assert property (p_spare) else $error("spare bits not zero");

	property p_off;
		quiet_q == 3'h7 && (mode_q == 8'h00 || mode_q > 8'h04) |-> process_data[0] == pol_q[0];
	endproperty
	a_off: assert property (p_off) else $error("deactivated channel not inactive");

	// ==========================================
	// Parameter access
	property p_rdpulse;
		param_req.rd |=> param_rd_valid;
	endproperty
	a_rdpulse: assert property (p_rdpulse) else $error("read answer missing");

	property p_rderr;
		param_rd_error |-> param_rd_valid && param_rd_data == 16'h0000;
	endproperty
	a_rderr: assert property (p_rderr) else $error("refused read not zero");

	property p_sp;
		param_req.rd && !param_req.channel && param_req.index == 8'h3C && param_req.subindex == 8'h01
			|=> param_rd_data == sp_q && !param_rd_error;
	endproperty
	a_sp: assert property (p_sp) else $error("setpoint read back wrong");
endmodule

bind pse_eval pse_eval_asserts pse_eval_asserts_i (.sys_clk, .reset, .meas, .meas_valid, .meas_under,
	.meas_over, .range_end, .param_req, .param_rd_data, .param_rd_valid, .param_rd_error, .pd_sent, .process_data);

`default_nettype wire

// [verification/pse_master_model.sv]
`timescale 1ns/1ps
`default_nettype none

module pse_master_model (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// Cycle gap between frames
	input  wire logic [7:0] gap,
	// Frame taken
	output logic            pd_sent
);
	// ==========================================
	// Cyclic transfer
	logic [7:0] cnt_q;

	// A larger gap models a slow master that leaves events between frames
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt_q   <= 8'h00;
			pd_sent <= 1'b0;
		end else begin
			cnt_q   <= (cnt_q >= gap) ? 8'h00 : cnt_q + 8'h01;
			pd_sent <= (cnt_q >= gap);
		end
	end
endmodule

`default_nettype wire

// [verification/pse_eval_test.sv]
`timescale 1ns/1ps
`default_nettype none

module pse_eval_test;
	// ==========================================
	// Stimulus and observation
	logic                    sys_clk    = 1'b0;
	logic                    reset      = 1'b1;
	pse_pkg::pse_meas_t      meas       = '0;
	logic                    meas_valid = 1'b0;
	logic                    meas_under = 1'b0;
	logic                    meas_over  = 1'b0;
	logic [15:0]             range_end  = 16'h7FF0;
	pse_pkg::pse_param_req_t param_req  = '0;
	logic [7:0]              gap        = 8'h04;
	logic [15:0]             param_rd_data;
	logic                    param_rd_valid;
	logic                    param_rd_error;
	logic                    pd_sent;
	logic [31:0]             process_data;
	logic [15:0]             d;
	logic [15:0]             exp_rd[$];
	logic [31:0]             exp_pd[$];
	int                      n_fail   = 0;
	int                      n_checks = 0;

	always #50 sys_clk = ~sys_clk;

	pse_eval pse_eval_i (.sys_clk, .reset, .meas, .meas_valid, .meas_under, .meas_over, .range_end,
		.param_req, .param_rd_data, .param_rd_valid, .param_rd_error, .pd_sent, .process_data);
	pse_master_model pse_master_model_i (.sys_clk, .reset, .gap, .pd_sent);

	// ==========================================
	// Comparison and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Bounded wait until every note has met its result
	task automatic drain();
		int i;
		for (i = 0; i < 200 && exp_rd.size() + exp_pd.size() > 0; i++)
			@(posedge sys_clk);
		if (i >= 200) begin
			n_fail++;
			$display("[FAIL] %0t no result", $time);
			conclude();
		end
	endtask

	// ==========================================
	// Parameter and measurement drivers
	task automatic wr(input logic ch, input logic [7:0] idx, sub, input logic [15:0] v);
		@(posedge sys_clk);
		param_req <= {1'b1, 1'b0, ch, idx, sub, v};
		@(posedge sys_clk);
		param_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic ch, input logic [7:0] idx, sub, input logic [15:0] e);
		exp_rd.push_back(e);
		@(posedge sys_clk);
		param_req <= {1'b0, 1'b1, ch, idx, sub, 16'h0000};
		@(posedge sys_clk);
		param_req.rd <= 1'b0;
		drain();
	endtask

	// Settle past the three-edge latency, then let the next frame be judged
	task automatic pos(input logic [15:0] p, ep, input logic [1:0] b);
		logic [1:0] q;
		q = 2'($urandom);
		@(posedge sys_clk);
		meas <= {p, 8'hFB, q};
		repeat (6) @(posedge sys_clk);
		exp_pd.push_back({ep, 8'hFB, 4'h0, q, b});
		drain();
	endtask

	// Results are taken off the oldest note as they appear
	always @(posedge sys_clk) begin
		if (param_rd_valid && exp_rd.size() > 0)
			check({16'h0000, param_rd_data}, {16'h0000, exp_rd.pop_front()});
		if (pd_sent && exp_pd.size() > 0)
			check(process_data, exp_pd.pop_front());
	end

	// ==========================================
	// Scenarios
	initial begin
		void'($urandom(32'h1412));
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		meas_valid <= 1'b1;
		rd(1'b0, 8'h3D, 8'h02, 16'h0000);
		rd(1'b1, 8'h55, 8'h01, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			d = 16'($urandom);
			wr(k[0], 8'h3C, {7'h00, k[1]} + 8'h01, d);
			rd(k[0], 8'h3C, {7'h00, k[1]} + 8'h01, d);
		end
		d = 16'($urandom);
		pos(d, d, 2'b00);
		wr(1'b1, 8'h3D, 8'h01, 16'h0001);
		pos(16'h1234, 16'h1234, 2'b10);
		$display("registers and deactivated done");
		wr(1'b0, 8'h3C, 8'h01, 16'h03E8);
		wr(1'b0, 8'h3D, 8'h03, 16'h0032);
		wr(1'b0, 8'h3D, 8'h02, 16'h0001);
		pos(16'h03E8, 16'h03E8, 2'b11);
		pos(16'h03C0, 16'h03C0, 2'b11);
		pos(16'h03B5, 16'h03B5, 2'b10);
		$display("single point done");
		gap <= 8'h20;
		wr(1'b0, 8'h3C, 8'h02, 16'h07D0);
		wr(1'b0, 8'h3D, 8'h02, 16'h0003);
		pos(16'h0898, 16'h0898, 2'b11);
		pos(16'h05DC, 16'h05DC, 2'b11);
		pos(16'h0320, 16'h0320, 2'b10);
		$display("two point done");
		wr(1'b1, 8'h3C, 8'h01, 16'h0BB8);
		wr(1'b1, 8'h3C, 8'h02, 16'h07D0);
		wr(1'b1, 8'h3D, 8'h03, 16'h0064);
		wr(1'b1, 8'h3D, 8'h02, 16'h0002);
		pos(16'h09C4, 16'h09C4, 2'b01);
		pos(16'h0BEA, 16'h0BEA, 2'b01);
		pos(16'h0C80, 16'h0C80, 2'b11);
		$display("window done");
		gap <= 8'h04;
		wr(1'b0, 8'h3C, 8'h01, 16'h1388);
		wr(1'b0, 8'h40, 8'h01, 16'h0064);
		wr(1'b0, 8'h3D, 8'h02, 16'h0004);
		pos(16'h13E2, 16'h13E2, 2'b11);
		pos(16'h1450, 16'h1450, 2'b10);
		$display("centered window done");
		wr(1'b0, 8'h40, 8'h03, 16'h0002);
		meas_valid <= 1'b0;
		pos(16'h1450, 16'h7FFC, 2'b11);
		meas_valid <= 1'b1;
		meas_under <= 1'b1;
		pos(16'h0000, 16'h8008, 2'b11);
		wr(1'b0, 8'h40, 8'h03, 16'h0001);
		meas_under <= 1'b0;
		meas_over <= 1'b1;
		pos(16'h7FF0, 16'h7FF8, 2'b10);
		$display("substitute done");
		conclude();
	end
endmodule

`default_nettype wire
